/* File: core/cfg_loader_pkg.sv */
// Shared constants, states and pin bundles of the parallel configuration loader.
// Assumes one 25 MHz core clock; all pin timing is derived from its period.
package cfg_loader_pkg;

  // Core clock period and the pin timing figures, in nanoseconds.
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_STATUS_MIN_NS = 2500;
  localparam int T_FIRST_ADDR_MAX_NS = 3500;
  localparam int T_BIT_HALF_NS = 80;

  // Least times round up, longest times round down.
  localparam int STATUS_MIN_CYC = (T_STATUS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIRST_ADDR_MAX_CYC = T_FIRST_ADDR_MAX_NS / CLK_PERIOD_NS;
  localparam int BIT_HALF_CYC = (T_BIT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_PERIOD_CYC = 2 * BIT_HALF_CYC;

  // Address and byte framing.
  localparam int ADDR_W = 18;
  localparam int BYTE_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_FIRST_UP = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_FIRST_DOWN = 18'h3FFFF;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] FRAME_HIGH_BITS = 3'h4;

  // Load scheme selected by the mode straps.
  typedef enum logic [1:0] {
    address_count_up_mode = 2'h0,
    address_count_down_mode = 2'h1,
    host_clocked_parallel_mode = 2'h2
  } load_mode_t;

  // Loader states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CLEAR = 6'h02,
    ST_LOAD = 6'h04,
    ST_RELEASE = 6'h08,
    ST_USER = 6'h10,
    ST_ERROR = 6'h20
  } load_state_t;

  // Open-drain handshake pins and PROM side pins driven by the loader.
  typedef struct packed {
    logic status_error_n_o;
    logic status_error_n_oe;
    logic config_complete_o;
    logic config_complete_oe;
    logic prom_oe_n;
    logic byte_frame_clock;
    logic serial_bit_clock_o;
    logic serial_bit_clock_oe;
    logic [ADDR_W-1:0] prom_addr;
  } cfg_pins_t;

  // Serial stream handed to the configuration memory.
  typedef struct packed {
    logic bit_value;
    logic bit_valid;
  } cfg_stream_t;

endpackage : cfg_loader_pkg

/* File: core/pin_sync.sv */
// Two-flop synchroniser for a group of pins.
// Assumes the inputs are asynchronous to mclk and that bits of a group may skew.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Pin side and synchronised side.
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // The first stage feeds only the second; nothing else may look at it.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync_out = sync_reg;

endmodule : pin_sync

/* File: core/parallel_config_loader.sv */
// Byte-wide configuration loader: active parallel PROM fetch and host-clocked load.
// Assumes open-drain pins are resolved outside and every pin input is asynchronous.
`timescale 1ns/1ps
module parallel_config_loader
  import cfg_loader_pkg::*;
#(
  parameter int CONFIG_BYTES = 1024
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic arst_n,
  // Configuration control pins.
  input wire logic config_request_n,
  input wire logic config_complete_i,
  input wire logic serial_bit_clock_i,
  input wire logic [BYTE_W-1:0] data_bus_i,
  input wire load_mode_t load_mode,
  // Error report from the configuration memory checker, on mclk.
  input wire logic frame_error,
  // Pin drives and loaded stream.
  output cfg_pins_t pins,
  output cfg_stream_t stream,
  output logic data_bus_release,
  output logic user_mode
);

  localparam int CNT_W = $clog2(CONFIG_BYTES + 1);
  localparam logic [CNT_W-1:0] BYTES_TOTAL = CNT_W'(CONFIG_BYTES);
  localparam logic [6:0] STATUS_MIN = 7'(STATUS_MIN_CYC);
  localparam logic [2:0] BIT_DIV_LAST = 3'(BIT_PERIOD_CYC - 1);
  localparam logic [2:0] BIT_DIV_HALF = 3'(BIT_HALF_CYC);

  // One address step in the selected direction.
  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                  input load_mode_t m);
    step_addr = (m == address_count_down_mode) ? a - 18'h00001 : a + 18'h00001;
  endfunction : step_addr

  // All pins except the load_mode straps pass two flops before any logic reads them.
  logic [BYTE_W+2:0] sync_out;
  logic req_n_s;
  logic complete_s;
  logic hclk_s;
  logic [BYTE_W-1:0] data_s;
  pin_sync #(.WIDTH(BYTE_W + 3)) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin_in({config_request_n, config_complete_i, serial_bit_clock_i, data_bus_i}),
    .pin_sync_out(sync_out)
  );
  assign {req_n_s, complete_s, hclk_s, data_s} = sync_out;

  load_state_t state_reg, state_next;
  logic [6:0] timer_reg, timer_next;
  logic [2:0] div_reg, div_next;
  logic [2:0] bit_reg, bit_next;
  logic [CNT_W-1:0] bytes_reg, bytes_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [BYTE_W-1:0] shift_reg, shift_next;
  logic have_reg, have_next;
  logic hclk_d_reg;
  logic out_bit_reg, out_bit_next;
  logic out_valid_reg, out_valid_next;
  logic host_mode;
  logic bit_tick;
  logic host_rise;
  logic host_fall;

  assign host_mode = (load_mode == host_clocked_parallel_mode);
  assign bit_tick = (state_reg == ST_LOAD) && !host_mode && (div_reg == BIT_DIV_LAST);
  assign host_rise = host_mode && hclk_s && !hclk_d_reg;
  assign host_fall = host_mode && !hclk_s && hclk_d_reg;

  // Sequencing, bit clock divider, address and shifter, all stepped together.
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    div_next = div_reg;
    bit_next = bit_reg;
    bytes_next = bytes_reg;
    addr_next = addr_reg;
    shift_next = shift_reg;
    have_next = have_reg;
    out_bit_next = 1'b0;
    out_valid_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        state_next = ST_CLEAR;
        timer_next = '0;
      end
      ST_CLEAR: begin
        if (timer_reg != STATUS_MIN) begin
          timer_next = timer_reg + 7'h01;
        end else if (req_n_s) begin
          state_next = ST_LOAD;
          div_next = '0;
          bit_next = '0;
          bytes_next = '0;
          have_next = 1'b0;
          addr_next = (load_mode == address_count_down_mode) ? ADDR_FIRST_DOWN
                                                             : ADDR_FIRST_UP;
        end
      end
      ST_LOAD: begin
        div_next = (div_reg == BIT_DIV_LAST) ? 3'h0 : div_reg + 3'h1;
        if (bit_tick || host_fall) begin
          out_bit_next = shift_reg[BYTE_W-1];
          out_valid_next = have_reg;
          shift_next = {shift_reg[BYTE_W-2:0], 1'b0};
          bit_next = bit_reg + 3'h1;
          if (bit_reg == BIT_LAST && host_mode) begin
            have_next = 1'b0;
            if (bytes_reg == BYTES_TOTAL) begin
              state_next = ST_RELEASE;
            end
          end
        end
        if (bit_tick && bit_reg == BIT_LAST) begin
          // Frame clock rises: take the addressed byte and step the address.
          if (bytes_reg == BYTES_TOTAL) begin
            state_next = ST_RELEASE;
          end else begin
            shift_next = data_s;
            have_next = 1'b1;
            bytes_next = bytes_reg + CNT_W'(1);
            addr_next = step_addr(addr_reg, load_mode);
          end
        end
        if (host_rise && bit_reg == 3'h0 && !have_reg && bytes_reg != BYTES_TOTAL) begin
          shift_next = data_s;
          have_next = 1'b1;
          bytes_next = bytes_reg + CNT_W'(1);
        end
      end
      ST_RELEASE: begin
        if (complete_s) begin
          state_next = ST_USER;
        end
      end
      ST_USER: begin
        state_next = ST_USER;
      end
      ST_ERROR: begin
        state_next = ST_ERROR;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (frame_error && (state_reg == ST_LOAD || state_reg == ST_RELEASE)) begin
      state_next = ST_ERROR;
    end
    // A request low always wins and restarts the load, even from an error.
    if (!req_n_s) begin
      state_next = ST_CLEAR;
      if (state_reg != ST_CLEAR) begin
        timer_next = '0;
      end
    end
  end

  // Registers only.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      div_reg <= '0;
      bit_reg <= '0;
      bytes_reg <= '0;
      addr_reg <= ADDR_FIRST_UP;
      shift_reg <= '0;
      have_reg <= 1'b0;
      hclk_d_reg <= 1'b0;
      out_bit_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      div_reg <= div_next;
      bit_reg <= bit_next;
      bytes_reg <= bytes_next;
      addr_reg <= addr_next;
      shift_reg <= shift_next;
      have_reg <= have_next;
      hclk_d_reg <= hclk_s;
      out_bit_reg <= out_bit_next;
      out_valid_reg <= out_valid_next;
    end
  end

  // Pin drives. Both handshake pins are open drain and only ever pull low.
  logic drive_status;
  logic drive_complete;
  assign drive_status = (state_reg == ST_IDLE) || (state_reg == ST_CLEAR)
                        || (state_reg == ST_ERROR);
  assign drive_complete = (state_reg == ST_IDLE) || (state_reg == ST_CLEAR)
                          || (state_reg == ST_LOAD) || (state_reg == ST_ERROR);
  always_comb begin
    pins.status_error_n_o = 1'b0;
    pins.status_error_n_oe = drive_status;
    pins.config_complete_o = 1'b0;
    pins.config_complete_oe = drive_complete;
    pins.prom_oe_n = !drive_complete;
    // The frame clock rises at each active-mode byte capture, so every rise also steps the address.
    pins.byte_frame_clock = (state_reg == ST_LOAD) && !host_mode && have_reg
                            && (bit_reg < FRAME_HIGH_BITS);
    pins.serial_bit_clock_o = (div_reg < BIT_DIV_HALF);
    pins.serial_bit_clock_oe = (state_reg == ST_LOAD) && !host_mode;
    pins.prom_addr = addr_reg;
  end
  assign stream.bit_value = out_bit_reg;
  assign stream.bit_valid = out_valid_reg;
  assign user_mode = (state_reg == ST_USER);
  assign data_bus_release = (state_reg == ST_USER);

  // Checks on the loader's own behaviour.
  localparam int FIRST_ADDR_BOUND = FIRST_ADDR_MAX_CYC;
  logic [6:0] low_cnt_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_reg <= '0;
    end else begin
      low_cnt_reg <= drive_status ? ((low_cnt_reg == 7'h7F) ? low_cnt_reg : low_cnt_reg + 7'h01)
                                  : 7'h00;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_status_on_request;
    $fell(req_n_s) |=> pins.status_error_n_oe;
  endproperty
  a_status_on_request: assert property (p_status_on_request) else $error("status not low");
  property p_complete_on_request;
    $fell(req_n_s) |=> pins.config_complete_oe && pins.prom_oe_n == 1'b0;
  endproperty
  a_complete_on_request: assert property (p_complete_on_request) else $error("done not low");
  property p_status_width;
    $fell(drive_status) |-> $past(low_cnt_reg) >= STATUS_MIN;
  endproperty
  a_status_width: assert property (p_status_width) else $error("status pulse short");
  property p_first_addr;
    $rose(req_n_s) |-> ##[1:FIRST_ADDR_BOUND] (state_reg == ST_LOAD);
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("first address late");
  property p_start_addr;
    $rose(state_reg == ST_LOAD) |-> pins.prom_addr ==
      ((load_mode == address_count_down_mode) ? ADDR_FIRST_DOWN : ADDR_FIRST_UP);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("wrong first address");
  property p_addr_step;
    (bit_tick && bit_reg == BIT_LAST && bytes_reg != BYTES_TOTAL) |=>
      pins.prom_addr == step_addr($past(addr_reg), load_mode);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address did not step");
  property p_release;
    (state_reg == ST_RELEASE) |-> !pins.config_complete_oe && pins.prom_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("done pin still driven");
  property p_user_entry;
    $rose(user_mode) |-> $past(complete_s) && data_bus_release;
  endproperty
  a_user_entry: assert property (p_user_entry) else $error("user mode without done");
  property p_error_hold;
    (state_reg == ST_ERROR && req_n_s) |=> pins.status_error_n_oe [*2];
  endproperty
  a_error_hold: assert property (p_error_hold) else $error("error not held");
  property p_host_capture;
    $rose(have_reg) && host_mode |-> $past(bit_reg) == 3'h0;
  endproperty
  a_host_capture: assert property (p_host_capture) else $error("capture off frame");

  c_user: cover property ($rose(user_mode));
  c_host_byte: cover property (host_mode && $rose(have_reg));
  c_error: cover property ($rose(state_reg == ST_ERROR));

endmodule : parallel_config_loader

/* File: testbench/prom_host_model.sv */
// Far-side model: parallel PROM with a slow option, the done pull-up and a host byte source.
// Assumes the loader's pin bundle is wired straight in and one 25 MHz mclk.
`timescale 1ns/1ps
module prom_host_model
  import cfg_loader_pkg::*;
(
  // Clock.
  input wire logic mclk,
  // Loader side.
  input wire logic [ADDR_W-1:0] prom_addr,
  input wire logic prom_oe_n,
  input wire logic done_oe,
  input wire logic status_oe,
  // Bench controls.
  input wire logic slow,
  input wire logic host_sel,
  input wire logic [BYTE_W-1:0] host_byte,
  // Resolved pins.
  output logic config_complete,
  output logic [BYTE_W-1:0] data_bus
);
  logic [ADDR_W-1:0] addr_reg = 18'h00000;
  logic [3:0] age_reg = 4'h0;
  logic [BYTE_W-1:0] last_reg = 8'h00;
  // The pull-up lifts the done net once nobody pulls it low.
  assign config_complete = ~done_oe;
  // Access age, so a slow part shows junk for six cycles after each new address.
  always_ff @(posedge mclk) begin
    addr_reg <= prom_addr;
    age_reg <= (prom_addr != addr_reg) ? 4'h0 : ((age_reg == 4'hF) ? age_reg : age_reg + 4'h1);
    last_reg <= data_bus;
  end
  // An undriven bus toggles, so a stale byte can never pass for data.
  always_comb begin
    if (host_sel) begin
      data_bus = host_byte;
    end else if (!prom_oe_n && !status_oe && !config_complete && (!slow || age_reg > 4'h5)) begin
      // Page logic serves bytes only while status is released and done is low.
      data_bus = prom_addr[7:0] ^ prom_addr[17:10] ^ 8'hA5;
    end else begin
      data_bus = ~last_reg;
    end
  end
endmodule : prom_host_model

/* File: testbench/parallel_config_loader_bench.sv */
// Self-checking bench of the loader: restart handshake, PROM fetch both ways, error, host load.
// Assumes the loader is built with a 4-byte terminal count to keep runs short.
`timescale 1ns/1ps
module parallel_config_loader_bench;
  import cfg_loader_pkg::*;
  localparam int NBYTES = 4;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic config_request_n = 1'b1;
  logic serial_bit_clock_i = 1'b0;
  logic frame_error = 1'b0;
  logic slow = 1'b0;
  logic host_sel = 1'b0;
  logic [BYTE_W-1:0] host_byte = 8'h00;
  load_mode_t load_mode = address_count_up_mode;
  logic config_complete_i;
  logic [BYTE_W-1:0] data_bus_i;
  cfg_pins_t pins;
  cfg_stream_t stream;
  logic data_bus_release;
  logic user_mode;
  int failures = 0;
  int comparisons = 0;
  logic bits[$];

  parallel_config_loader #(.CONFIG_BYTES(NBYTES)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .config_request_n(config_request_n),
    .config_complete_i(config_complete_i), .serial_bit_clock_i(serial_bit_clock_i),
    .data_bus_i(data_bus_i), .load_mode(load_mode), .frame_error(frame_error),
    .pins(pins), .stream(stream), .data_bus_release(data_bus_release), .user_mode(user_mode));

  prom_host_model i_far (
    .mclk(mclk), .prom_addr(pins.prom_addr), .prom_oe_n(pins.prom_oe_n),
    .done_oe(pins.config_complete_oe), .status_oe(pins.status_error_n_oe),
    .slow(slow), .host_sel(host_sel),
    .host_byte(host_byte), .config_complete(config_complete_i), .data_bus(data_bus_i));

  // Clock at 25 MHz.
  initial begin
    forever #20 mclk = ~mclk;
  end

  // Every serial bit the loader hands on is kept, sampled where it has settled.
  always @(negedge mclk) begin
    if (stream.bit_valid === 1'b1) begin
      bits.push_back(stream.bit_value);
    end
  end

  // Same byte pattern as the PROM model stores.
  function automatic logic [BYTE_W-1:0] prom_byte(logic [ADDR_W-1:0] a);
    return a[7:0] ^ a[17:10] ^ 8'hA5;
  endfunction : prom_byte

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic test_done();
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // Low pulse on the request pin; measures status and done timing around it.
  task automatic pulse_request(logic chk_addr);
    int n;
    config_request_n = 1'b0;
    n = 0;
    while (!(pins.status_error_n_oe === 1'b1 && pins.config_complete_oe === 1'b1) && n < 40) begin
      cyc(1);
      n++;
    end
    check("request fall to status and done low", 1, n <= 25);
    cyc(50);
    config_request_n = 1'b1;
    n = 0;
    while (pins.status_error_n_oe === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    check("status low width", 1, n + 50 >= STATUS_MIN_CYC);
    if (chk_addr) begin
      check("first address time", 1, n <= FIRST_ADDR_MAX_CYC + 1);
      check("first address", (load_mode == address_count_down_mode) ? 18'h3FFFF : 18'h00000,
            pins.prom_addr);
    end
    bits.delete();
  endtask : pulse_request

  // Serial stream and the pin state of user mode after a full load.
  task automatic check_done(logic [BYTE_W-1:0] exp [NBYTES]);
    check("bit count", NBYTES * 8, bits.size());
    for (int i = 0; i < NBYTES * 8 && i < bits.size(); i++) begin
      check("stream bit", exp[i / 8][7 - i % 8], bits[i]);
    end
    check("user mode", 1, user_mode);
    check("data pins released", 1, data_bus_release);
    check("prom output enable off", 1, pins.prom_oe_n);
    check("done pull released", 0, pins.config_complete_oe);
  endtask : check_done

  // Active parallel load with address stepping and frame timing watched.
  task automatic run_active(load_mode_t m, logic s);
    logic [ADDR_W-1:0] prev;
    logic [ADDR_W-1:0] step;
    logic [BYTE_W-1:0] exp [NBYTES];
    logic frame_prev;
    logic framed;
    logic clk_prev;
    logic clk_now;
    int clks;
    int since;
    int n;
    load_mode = m;
    slow = s;
    host_sel = 1'b0;
    step = (m == address_count_down_mode) ? 18'h3FFFF : 18'h00001;
    pulse_request(1'b1);
    prev = pins.prom_addr;
    for (int i = 0; i < NBYTES; i++) begin
      exp[i] = prom_byte(ADDR_W'(prev + step * ADDR_W'(i)));
    end
    frame_prev = 1'b0;
    framed = 1'b0;
    clk_prev = 1'b0;
    clks = 0;
    since = 99;
    n = 0;
    while (user_mode !== 1'b1 && n < 800) begin
      cyc(1);
      n++;
      // Eight bit clock rises must fall between two frame clock rises.
      if (pins.byte_frame_clock === 1'b1 && !frame_prev) begin
        if (framed) begin
          check("bit clocks per frame", 8, clks);
        end
        framed = 1'b1;
        clks = 0;
      end
      clk_now = pins.serial_bit_clock_oe === 1'b1 && pins.serial_bit_clock_o === 1'b1;
      if (clk_now && !clk_prev) begin
        clks++;
      end
      clk_prev = clk_now;
      since = (pins.byte_frame_clock === 1'b1 && !frame_prev) ? 0 : since + 1;
      frame_prev = (pins.byte_frame_clock === 1'b1);
      if (pins.config_complete_oe === 1'b1 && pins.prom_addr !== prev) begin
        check("address step", ADDR_W'(prev + step), pins.prom_addr);
        check("frame rise to address", 1, since <= 25);
        prev = pins.prom_addr;
      end
    end
    check_done(exp);
  endtask : run_active

  // A load error pulls status low and holds it; no user mode follows.
  task automatic run_error();
    load_mode = address_count_up_mode;
    host_sel = 1'b0;
    pulse_request(1'b1);
    cyc(60);
    frame_error = 1'b1;
    cyc(1);
    frame_error = 1'b0;
    cyc(100);
    check("status held after error", 1, pins.status_error_n_oe);
    check("user mode after error", 0, user_mode);
    check("status pin level", 0, pins.status_error_n_o);
    check("done pin level", 0, pins.config_complete_o);
  endtask : run_error

  // Host-clocked load: 120 ns phases, one byte per eight clocks.
  task automatic run_host();
    logic [BYTE_W-1:0] exp [NBYTES] = '{8'h3C, 8'hC3, 8'h5A, 8'h81};
    int n;
    load_mode = host_clocked_parallel_mode;
    host_sel = 1'b1;
    pulse_request(1'b0);
    cyc(130);
    for (int b = 0; b < NBYTES; b++) begin
      host_byte = exp[b];
      repeat (8) begin
        cyc(3);
        serial_bit_clock_i = 1'b1;
        cyc(3);
        serial_bit_clock_i = 1'b0;
      end
    end
    n = 0;
    while (user_mode !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    check("done pin seen high", 1, config_complete_i);
    check_done(exp);
    host_sel = 1'b0;
  endtask : run_host

  // Main sequence; reset is held for twelve cycles first.
  initial begin
    cyc(12);
    arst_n = 1'b1;
    check("address width", 18, $bits(pins.prom_addr));
    run_active(address_count_up_mode, 1'b0);
    run_active(address_count_down_mode, 1'b1);
    run_error();
    run_active(address_count_up_mode, 1'b0);
    load_mode = address_count_up_mode;
    pulse_request(1'b1);
    cyc(120);
    run_active(address_count_down_mode, 1'b0);
    run_host();
    test_done();
  end

  // Watchdog: the whole sequence needs well under 6000 cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    test_done();
  end
endmodule : parallel_config_loader_bench
